// file: common/vdsk_defs.svh
`ifndef VDSK_DEFS_SVH
`define VDSK_DEFS_SVH
// Contract
// [RULE1] A one-word packed skip instruction discards its 12-bit byte count from the pixel FIFO.
// [RULE2] Skips start and stop at any byte lane of a 32-bit FIFO word.
// [RULE3] A two-word planar skip discards the first byte count from the luma FIFO.
// [RULE4] The planar skip discards chroma bytes from FIFO two and three, counts from word two.
// [RULE5] Word one holds opcode, line start, line end, interrupt and status set/reset fields.
// [RULE6] Continue-write starts at the target address counter, kept current in skips and overruns.
// [RULE7] Software never sets line start in a continue-write instruction.
// [RULE8] An early FIFO end of line aborts instructions up to the one with the line end flag.

// ==========================================================
// Opcodes
`define VDSK_OP_SKIP     4'h2
`define VDSK_OP_PLANAR   4'ha
`define VDSK_OP_CONT_WR  4'h5

// ==========================================================
// Instruction word fields
`define VDSK_OP_MSB      31
`define VDSK_OP_LSB      28
`define VDSK_SOL_BIT     27
`define VDSK_EOL_BIT     26
`define VDSK_IRQ_BIT     24
`define VDSK_SET_MSB     23
`define VDSK_SET_LSB     20
`define VDSK_RST_MSB     19
`define VDSK_RST_LSB     16
`define VDSK_BE_MSB      15
`define VDSK_BE_LSB      12
`define VDSK_CNT_MSB     11
`define VDSK_CNT_LSB     0
`define VDSK_CNT3_MSB    27
`define VDSK_CNT3_LSB    16

// ==========================================================
// Sizes and reset values
`define VDSK_PLANES      3
`define VDSK_BUF_DEPTH   8
`define VDSK_LAST_LANE   2'h3
`define VDSK_OVR_BYTES   32'h0000_0004
`define VDSK_STS_RESET   4'h0
`define VDSK_ADDR_RESET  32'h0000_0000
`endif

// file: common/vdsk_pkg.sv
package vdsk_pkg;
	typedef enum logic [1:0] {
		VDSK_IDLE  = 2'b00,
		VDSK_WORD1 = 2'b01,
		VDSK_RUN   = 2'b10
	} vdsk_state_e;

	typedef logic [11:0] vdsk_cnt_t;
	typedef logic [1:0]  vdsk_lane_t;
endpackage

// file: src/vdsk_fifo.sv
`timescale 1ns/1ps
module vdsk_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             sys_rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      fill_q;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (fill_q != (AW+1)'(DEPTH));
	assign out_valid_o = (fill_q != '0);
	assign out_data_o  = mem_q[rptr_q];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
			end
			fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // vdsk_fifo

// file: src/vdsk_decoder.sv
`timescale 1ns/1ps
`include "vdsk_defs.svh"
module vdsk_decoder
	import vdsk_pkg::*;
#(
	parameter int BUF_DEPTH = `VDSK_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// Instruction words from the fetch unit
	input  wire logic        instr_valid_i,
	output logic             instr_ready_o,
	input  wire logic [31:0] instr_word_i,
	output logic             instr_done_o,
	output logic             bad_instr_o,
	// Pixel FIFOs: plane 0 luma or packed, 1 and 2 chroma
	input  wire logic [2:0]  pix_valid_i,
	output logic      [2:0]  pix_ready_o,
	input  wire logic [31:0] pix0_data_i,
	input  wire logic [31:0] pix1_data_i,
	input  wire logic [31:0] pix2_data_i,
	input  wire logic        fifo_eol_i,
	input  wire logic        fifo_overrun_i,
	// Target address counter load from the addressed write path
	input  wire logic        addr_load_i,
	input  wire logic [31:0] addr_value_i,
	output logic      [31:0] target_addr_o,
	// Byte writes to memory
	output logic             wr_valid_o,
	input  wire logic        wr_ready_i,
	output logic      [31:0] wr_addr_o,
	output logic      [7:0]  wr_data_o,
	// Status and events
	output logic      [3:0]  sequencer_status_flags_o,
	output logic             irq_req_o,
	output logic             line_start_flag_o,
	output logic             line_end_flag_o,
	output logic             aborting_o
);
	// ==========================================================
	// Registers
	vdsk_state_e state_q;
	logic        planar_q;
	logic        write_q;
	logic        drop_q;
	logic        abort_q;
	logic        irq_q;
	logic        eol_q;
	logic [3:0]  set_q;
	logic [3:0]  rst_q;
	logic [3:0]  be_q;
	logic [3:0]  sts_q;
	logic [31:0] addr_q;
	logic        done_q;
	logic        bad_q;
	logic        irq_out_q;
	logic        sol_out_q;
	logic        eol_out_q;
	vdsk_cnt_t   cnt_q  [`VDSK_PLANES];
	vdsk_lane_t  lane_q [`VDSK_PLANES];

	// ==========================================================
	// Decode
	wire [3:0]  opcode    = instr_word_i[`VDSK_OP_MSB:`VDSK_OP_LSB];
	wire        op_skip   = (opcode == `VDSK_OP_SKIP);
	wire        op_planar = (opcode == `VDSK_OP_PLANAR);
	wire        op_cont   = (opcode == `VDSK_OP_CONT_WR);
	wire        sol_bit   = instr_word_i[`VDSK_SOL_BIT];
	wire        eol_bit   = instr_word_i[`VDSK_EOL_BIT];
	// A continue-write cannot open a line, so a set start flag is an error
	wire        op_ok     = op_skip || op_planar || (op_cont && !sol_bit); // RULE7
	wire        take_w0   = (state_q == VDSK_IDLE) && instr_valid_i;
	wire        take_w1   = (state_q == VDSK_WORD1) && instr_valid_i;
	wire        start     = take_w0 && op_ok;
	wire        ld0       = start && !abort_q;
	wire        ld12      = take_w1 && !drop_q;
	wire        early_eol = (state_q == VDSK_RUN) && fifo_eol_i;
	wire        cnt_zero  = (cnt_q[0] == '0) && (cnt_q[1] == '0) && (cnt_q[2] == '0);
	wire        finish    = (state_q == VDSK_RUN) && (cnt_zero || early_eol);
	wire        finish_ok = finish && !drop_q;

	assign instr_ready_o = (state_q == VDSK_IDLE) || (state_q == VDSK_WORD1);

	// ==========================================================
	// Per-plane byte consumption
	wire [31:0] pix_word [`VDSK_PLANES];
	wire [11:0] ld_val   [`VDSK_PLANES];
	wire [2:0]  ld_en;
	wire [2:0]  take;
	wire        buf_in_ready;

	assign pix_word[0] = pix0_data_i;
	assign pix_word[1] = pix1_data_i;
	assign pix_word[2] = pix2_data_i;
	assign ld_val[0]   = instr_word_i[`VDSK_CNT_MSB:`VDSK_CNT_LSB]; // RULE1 RULE3
	assign ld_val[1]   = instr_word_i[`VDSK_CNT_MSB:`VDSK_CNT_LSB]; // RULE4
	assign ld_val[2]   = instr_word_i[`VDSK_CNT3_MSB:`VDSK_CNT3_LSB]; // RULE4
	assign ld_en       = {ld12, ld12, ld0};

	genvar p;
	generate
		for (p = 0; p < `VDSK_PLANES; p++) begin : g_plane
			// Plane 0 stalls on a full write buffer only when writing
			wire stall = (p == 0) && write_q && !buf_in_ready;
			assign take[p] = (state_q == VDSK_RUN) && (cnt_q[p] != '0) && pix_valid_i[p] && !stall;
			// Word pops only once its last lane is used, so kept bytes survive
			assign pix_ready_o[p] = take[p] && (lane_q[p] == `VDSK_LAST_LANE); // RULE2

			always_ff @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					cnt_q[p]  <= '0;
					lane_q[p] <= '0;
				end else if (ld_en[p]) begin
					cnt_q[p] <= ld_val[p];
				end else if (early_eol) begin
					cnt_q[p] <= '0; // RULE8
				end else if (take[p]) begin
					cnt_q[p]  <= cnt_q[p] - 12'h001; // RULE1 RULE3 RULE4
					lane_q[p] <= lane_q[p] + 2'h1; // RULE2
				end
			end
		end
	endgenerate

	// ==========================================================
	// Write buffer: only continue-write bytes with their lane enabled
	wire [7:0] cur_byte    = pix_word[0][{lane_q[0], 3'b000} +: 8];
	wire       buf_in_valid = take[0] && write_q && be_q[lane_q[0]]; // RULE6
	wire [39:0] buf_out;

	vdsk_fifo #(
		.WIDTH (40),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   ({addr_q, cur_byte}),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  (buf_out)
	);

	assign wr_addr_o = buf_out[39:8];
	assign wr_data_o = buf_out[7:0];

	// ==========================================================
	// Target address counter, advanced by skips, writes and overruns
	// Both steps add up, so an overrun beside a byte loses neither
	wire [31:0] ovr_step  = fifo_overrun_i ? `VDSK_OVR_BYTES : 32'h0000_0000;
	wire [31:0] take_step = {31'h0000_0000, take[0]};

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			addr_q <= `VDSK_ADDR_RESET;
		end else if (addr_load_i) begin
			addr_q <= addr_value_i;
		end else if (fifo_overrun_i || take[0]) begin
			addr_q <= addr_q + ovr_step + take_step; // RULE6
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_q <= VDSK_IDLE;
		end else begin
			unique case (state_q)
				VDSK_IDLE: begin
					if (start) begin
						state_q <= op_planar ? VDSK_WORD1 : VDSK_RUN;
					end
				end
				VDSK_WORD1: begin
					if (take_w1) begin
						state_q <= VDSK_RUN;
					end
				end
				VDSK_RUN: begin
					if (finish) begin
						state_q <= VDSK_IDLE;
					end
				end
				default: state_q <= VDSK_IDLE;
			endcase
		end
	end

	// Fields of word one held for the life of the instruction
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			planar_q <= 1'b0;
			write_q  <= 1'b0;
			drop_q   <= 1'b0;
			irq_q    <= 1'b0;
			eol_q    <= 1'b0;
			set_q    <= '0;
			rst_q    <= '0;
			be_q     <= '0;
		end else if (start) begin
			planar_q <= op_planar;
			write_q  <= op_cont && !abort_q;
			drop_q   <= abort_q;
			irq_q    <= instr_word_i[`VDSK_IRQ_BIT]; // RULE5
			eol_q    <= eol_bit; // RULE5
			set_q    <= instr_word_i[`VDSK_SET_MSB:`VDSK_SET_LSB]; // RULE5
			rst_q    <= instr_word_i[`VDSK_RST_MSB:`VDSK_RST_LSB]; // RULE5
			be_q     <= op_cont ? instr_word_i[`VDSK_BE_MSB:`VDSK_BE_LSB] : 4'hf;
		end
	end

	// Abort lasts until the instruction carrying the line end flag
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			abort_q <= 1'b0;
		end else if (early_eol && !eol_q) begin
			abort_q <= 1'b1; // RULE8
		end else if (start && abort_q && eol_bit) begin
			abort_q <= 1'b0; // RULE8
		end
	end

	// Status flags: set wins over reset in the same instruction
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sts_q <= `VDSK_STS_RESET;
		end else if (finish_ok) begin
			sts_q <= (sts_q & ~rst_q) | set_q; // RULE5
		end
	end

	// Event pulses
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			done_q    <= 1'b0;
			bad_q     <= 1'b0;
			irq_out_q <= 1'b0;
			sol_out_q <= 1'b0;
			eol_out_q <= 1'b0;
		end else begin
			done_q    <= finish;
			bad_q     <= take_w0 && !op_ok;
			irq_out_q <= finish_ok && irq_q; // RULE5
			sol_out_q <= ld0 && sol_bit; // RULE5
			eol_out_q <= finish && eol_q; // RULE5
		end
	end

	assign instr_done_o             = done_q;
	assign bad_instr_o              = bad_q;
	assign irq_req_o                = irq_out_q;
	assign line_start_flag_o        = sol_out_q;
	assign line_end_flag_o          = eol_out_q;
	assign aborting_o               = abort_q;
	assign target_addr_o            = addr_q;
	assign sequencer_status_flags_o = sts_q;
endmodule // vdsk_decoder

// file: verif/vdsk_decoder_asserts.sv
`timescale 1ns/1ps
module vdsk_decoder_asserts
	import vdsk_pkg::*;
#(
	parameter int BUF_DEPTH = 8
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// Watched ports
	input  wire logic        instr_valid_i,
	input  wire logic        instr_ready_o,
	input  wire logic [31:0] instr_word_i,
	input  wire logic        instr_done_o,
	input  wire logic [2:0]  pix_valid_i,
	input  wire logic [2:0]  pix_ready_o,
	input  wire logic        fifo_overrun_i,
	input  wire logic        addr_load_i,
	input  wire logic [31:0] addr_value_i,
	input  wire logic [31:0] target_addr_o,
	input  wire logic        irq_req_o,
	input  wire logic        line_start_flag_o,
	input  wire logic        line_end_flag_o,
	input  wire logic        aborting_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	// ==========================================================
	// Discard, finish and line start
	a_pop_needs_valid: assert property ((pix_ready_o & ~pix_valid_i) == 3'h0)
		else $error("plane popped without valid");
	a_done_after_run: assert property (instr_done_o |-> !$past(instr_ready_o))
		else $error("done without a running instruction");
	a_irq_at_done: assert property (irq_req_o |-> instr_done_o)
		else $error("irq outside instruction end");
	a_eol_at_done: assert property (line_end_flag_o |-> instr_done_o)
		else $error("line end outside instruction end");
	a_sol_from_word: assert property (line_start_flag_o |->
		$past(instr_valid_i && instr_ready_o && instr_word_i[27]))
		else $error("line start without flagged word");

	// ==========================================================
	// Target address counter stays current; abort ends its instruction
	a_ovr_advance: assert property (fifo_overrun_i && !addr_load_i && instr_ready_o
		|=> target_addr_o == $past(target_addr_o) + 32'h4)
		else $error("overrun did not advance address");
	a_addr_load: assert property (addr_load_i |=> target_addr_o == $past(addr_value_i))
		else $error("address load lost");
	a_addr_idle_hold: assert property (instr_ready_o && !addr_load_i && !fifo_overrun_i
		|=> $stable(target_addr_o))
		else $error("address moved while idle");
	a_abort_finishes: assert property ($rose(aborting_o) |-> ##[0:1] instr_done_o)
		else $error("abort did not finish instruction");
endmodule // vdsk_decoder_asserts

bind vdsk_decoder vdsk_decoder_asserts #(.BUF_DEPTH(BUF_DEPTH)) u_vdsk_decoder_asserts (
	.clk_sys_i, .sys_rst_i, .instr_valid_i, .instr_ready_o, .instr_word_i, .instr_done_o,
	.pix_valid_i, .pix_ready_o, .fifo_overrun_i, .addr_load_i, .addr_value_i, .target_addr_o,
	.irq_req_o, .line_start_flag_o, .line_end_flag_o, .aborting_o);

// file: verif/vdsk_host_model.sv
`timescale 1ns/1ps
module vdsk_host_model (
	// Clock
	input  wire logic        clk_i,
	// Instruction fetch handshake
	input  wire logic        ready_i,
	output logic             valid_o,
	output logic      [31:0] word_o
);
	initial begin
		valid_o = 1'b0;
		word_o  = 32'h0;
	end

	// Word held until the accepting edge; released bus shows inverted data
	task automatic send(input logic [31:0] w, output bit ok);
		int n;
		@(negedge clk_i);
		valid_o = 1'b1;
		word_o  = w;
		for (n = 0; n < 200 && ready_i !== 1'b1; n++) @(negedge clk_i);
		ok = n < 200;
		@(posedge clk_i);
		@(negedge clk_i);
		valid_o = 1'b0;
		word_o  = ~w;
	endtask
endmodule // vdsk_host_model

// file: verif/video_dma_skip_write_decoder_tb.sv
`timescale 1ns/1ps
module video_dma_skip_write_decoder_tb;
	import vdsk_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        vld, rdy, done, bad, wv, irq, lsf, lef, abt;
	logic        line_end_flag = 1'b0, ovr = 1'b0, ld = 1'b0;
	logic [31:0] word, tad, wa, a;
	logic [31:0] ldv = 32'h0;
	logic [2:0]  pv  = 3'h7;
	logic        wrr = 1'b1;
	logic [2:0]  prdy;
	logic [7:0]  wd;
	logic [3:0]  sts;
	logic [31:0] bw [2] = '{32'h5800_0001, 32'h0000_0000};
	logic [39:0] wq [$];
	int          fail_count = 0, checks = 0, ev = 0, bads = 0, eols = 0;
	int          pops [3] = '{0, 0, 0};

	initial forever #12.5 clk_sys_i = ~clk_sys_i;

	vdsk_decoder u_vdsk_decoder (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.instr_valid_i(vld), .instr_ready_o(rdy), .instr_word_i(word), .instr_done_o(done),
		.bad_instr_o(bad), .pix_valid_i(pv), .pix_ready_o(prdy), .pix0_data_i(32'h4433_2211),
		.pix1_data_i(32'h0), .pix2_data_i(32'h0), .fifo_eol_i(line_end_flag), .fifo_overrun_i(ovr),
		.addr_load_i(ld), .addr_value_i(ldv), .target_addr_o(tad), .wr_valid_o(wv),
		.wr_ready_i(wrr), .wr_addr_o(wa), .wr_data_o(wd), .sequencer_status_flags_o(sts),
		.irq_req_o(irq), .line_start_flag_o(lsf), .line_end_flag_o(lef), .aborting_o(abt));
	vdsk_host_model u_vdsk_host_model (.clk_i(clk_sys_i), .ready_i(rdy), .valid_o(vld),
		.word_o(word));

	// ==========================================================
	// Event monitor
	always @(posedge clk_sys_i) begin
		for (int p = 0; p < 3; p++) pops[p] += prdy[p];
		ev += irq + lsf;
		eols += lef;
		bads += bad;
		// Only a byte that is actually accepted counts as written
		if (wv && wrr) wq.push_back({wa, wd});
	end

	// ==========================================================
	// Tasks
	task automatic results();
		if (fail_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic give(input logic [31:0] w);
		bit ok;
		u_vdsk_host_model.send(w, ok);
		if (!ok) begin
			fail_count++;
			results();
		end
	endtask
	// Done is a one-cycle pulse, so poll every cycle
	task automatic fin();
		int n;
		for (n = 0; n < 500 && done !== 1'b1; n++) @(negedge clk_sys_i);
		if (n == 500) begin
			fail_count++;
			results();
		end
		@(negedge clk_sys_i);
	endtask
	task automatic run(input logic [31:0] w0, input logic [31:0] w1 = 32'h0, input bit two = 0);
		give(w0);
		if (two) give(w1);
		fin();
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		repeat (3) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		run(32'h2d50_0005);
		run(32'h2000_0003);
		chk("pops0", pops[0], 2);
		chk("addr", tad, 32'h8);
		chk("status", sts, 4'h5);
		chk("events", ev, 2);
		chk("eols", eols, 1);
		run(32'ha001_0004, 32'h0008_0004, 1);
		chk("pops0", pops[0], 3);
		chk("pops1", pops[1], 1);
		chk("pops2", pops[2], 2);
		chk("status", sts, 4'h4);
		chk("addr", tad, 32'hc);
		ld = 1'b1;
		ldv = 32'h100;
		@(negedge clk_sys_i);
		ld = 1'b0;
		run(32'h5000_f002);
		repeat (4) @(negedge clk_sys_i);
		chk("wr0", wq[0], {32'h100, 8'h11});
		chk("wr1", wq[1], {32'h101, 8'h22});
		ovr = 1'b1;
		@(negedge clk_sys_i);
		ovr = 1'b0;
		chk("addr", tad, 32'h106);
		// Deliberately illegal words: line start in continue-write, reserved opcode
		foreach (bw[i]) begin
			give(bw[i]);
			@(negedge clk_sys_i);
		end
		chk("bad", bads, 2);
		chk("nwr", wq.size(), 2);
		chk("addr", tad, 32'h106);
		give(32'h2000_00ff);
		repeat (3) @(negedge clk_sys_i);
		line_end_flag = 1'b1;
		@(negedge clk_sys_i);
		line_end_flag = 1'b0;
		@(negedge clk_sys_i);
		chk("abort", abt, 1'b1);
		a = tad;
		run(32'h2110_0010);
		run(32'h2510_0010);
		chk("abort", abt, 1'b0);
		chk("events", ev, 2);
		chk("status", sts, 4'h4);
		chk("addr", tad, a);
		chk("eols", eols, 2);
		// No byte leaves an empty pixel FIFO
		pv = 3'h6;
		give(32'h2000_0002);
		repeat (3) @(negedge clk_sys_i);
		chk("stall", tad, a);
		pv = 3'h7;
		fin();
		chk("addr", tad, a + 32'h2);
		// Full write buffer holds plane 0 and the address counter
		ld = 1'b1;
		ldv = 32'h200;
		@(negedge clk_sys_i);
		ld = 1'b0;
		wrr = 1'b0;
		give(32'h5000_f00a);
		repeat (12) @(negedge clk_sys_i);
		chk("full", tad, 32'h208);
		wrr = 1'b1;
		fin();
		repeat (10) @(negedge clk_sys_i);
		chk("nwr", wq.size(), 12);
		chk("lastwr", wq[11][39:8], 32'h209);
		chk("addr", tad, 32'h20a);
		results();
	end
endmodule // video_dma_skip_write_decoder_tb
